/* verilog/osl_pkg.sv */
// constants and types for the setpoint and limit register block
`default_nettype none
package osl_pkg;
   // command codes on the management bus
   localparam logic [7:0]  CMD_STORE      = 8'h11;
   localparam logic [7:0]  CMD_MODE       = 8'h20;
   localparam logic [7:0]  CMD_SETPOINT   = 8'h21;
   localparam logic [7:0]  CMD_UPPER      = 8'h24;
   localparam logic [7:0]  CMD_SLEW       = 8'h27;
   localparam logic [7:0]  CMD_DIVIDER    = 8'h29;
   // fixed linear-format exponents
   localparam logic [7:0]  MODE_BYTE      = 8'h17;
   localparam logic [4:0]  SLEW_EXP       = 5'h1a;
   localparam logic [4:0]  DIV_EXP        = 5'h1e;
   // setpoint codes
   localparam logic [15:0] SP_RESET       = 16'h0100;
   localparam logic [15:0] SP_INVALID     = 16'h0b00;
   localparam logic [15:0] SP_MIN_FULL    = 16'h00b3;
   localparam logic [15:0] SP_MAX_FULL    = 16'h034d;
   localparam logic [15:0] SP_MIN_HALF    = 16'h0166;
   localparam logic [15:0] SP_MAX_HALF    = 16'h0400;
   // upper limit codes
   localparam logic [15:0] UP_MIN_FULL    = 16'h011a;
   localparam logic [15:0] UP_MAX_FULL    = 16'h034d;
   localparam logic [15:0] UP_MIN_HALF    = 16'h0234;
   localparam logic [15:0] UP_MAX_HALF    = 16'h069a;
   // slew rate mantissa
   localparam logic [10:0] SLEW_RESET     = 11'h03c;
   localparam int          SLEW_BUCKETS   = 8;
   localparam logic [10:0] SLEW_EDGE [SLEW_BUCKETS-1] =
      '{11'h005, 11'h007, 11'h00c, 11'h011, 11'h019, 11'h02f, 11'h04f};
   // divider ratio mantissa
   localparam logic [10:0] DIV_FULL       = 11'h004;
   localparam logic [10:0] DIV_HALF       = 11'h002;
   // sticky flag positions
   localparam int          F_COMM_ERR     = 0;
   localparam int          F_INVALID_DATA = 1;
   localparam int          F_INVALID_CMD  = 2;
   localparam int          F_OTHER_COND   = 3;
   localparam int          F_OUTPUT_WARN  = 4;
   localparam int          F_LIMIT_WARN   = 5;
   localparam int          NUM_FLAGS      = 6;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_CMD  = 3'b010,
      ST_D0   = 3'b011,
      ST_D1   = 3'b100,
      ST_RD   = 3'b101
   } osl_state_t;
endpackage
`default_nettype wire

/* verilog/osl_link_if.sv */
// carrier for sampled link bits between clock domains
`default_nettype none
interface osl_link_if;
   logic bit_tgl;
   logic bit_val;
   modport link (output bit_tgl, output bit_val);
   modport core (input bit_tgl, input bit_val);
endinterface
`default_nettype wire

/* verilog/osl_bit_capture.sv */
// samples the data line on each rising link clock edge
`default_nettype none
module osl_bit_capture (
   input  wire logic i_scl,
   input  wire logic i_sda,
   osl_link_if.link  lnk
);
   // link clock stands still between frames, so no reset here
   logic tgl_q = 1'b0;
   logic val_q = 1'b0;

   always_ff @(posedge i_scl) begin
      val_q <= i_sda;
      tgl_q <= ~tgl_q;
   end

   // value stays put until the next rising edge, long after the toggle lands
   assign lnk.bit_val = val_q;
   assign lnk.bit_tgl = tgl_q;
endmodule
`default_nettype wire

/* verilog/osl_regs.sv */
// setpoint, upper limit and slew rate registers behind a management bus slave
`default_nettype none
// Function
// - voltage registers use linear format, exponent -9
// - setpoint saved on store-defaults command
// - loop slave: ignore, nack, invalid command, alert
// - setpoint accepted 179-845 or 358-1024
// - setpoint above 2816 nacked, kept, flagged
// - written setpoint clamped to violated limit
// - setpoint resets to code 256
// - upper limit applies to every setpoint change
// - top reference equals limit times ratio
// - output on, over limit: clamp to upper
// - limit violation while output on sets three flags and alert
// - ratio 1: upper 282-845, default 845
// - ratio 0.5: upper 564-1690, default 1690 (not loaded: a ratio write leaves upper at its old value)
// - programmed slew used for normal changes
// - exactly eight fixed slew rates
// - mantissa thresholds select slew bucket
// - slew exponent fixed -6, default 60
// - lower limit clamps with same flags
// - divider only 4 or 2, else invalid
module osl_regs #(
   parameter logic [6:0] SLAVE_ADDR = 7'h24  // arbitrary default address
) (
   input  wire logic        i_clk,
   input  wire logic        i_srst,
   input  wire logic        i_scl,
   input  wire logic        i_sda,
   output logic             o_sda,
   output logic             o_sda_oe,
   output logic             o_alert_oe,
   input  wire logic        i_loop_slave,
   input  wire logic        i_output_on,
   input  wire logic [15:0] i_lower_limit,
   input  wire logic [15:0] i_ref_adjust,
   input  wire logic        i_flags_clear,
   output logic [15:0]      o_ref_code,
   output logic [2:0]       o_slew_sel,
   output logic             o_store_req,
   output logic [15:0]      o_store_setpoint,
   output logic [5:0]       o_flags
);
   ////////////////////////////////////////////////////////////////////////
   osl_link_if lnk ();

   osl_bit_capture u_cap (
      .i_scl (i_scl),
      .i_sda (i_sda),
      .lnk   (lnk.link)
   );

   logic [1:0] scl_s_q;
   logic [1:0] sda_s_q;
   logic [1:0] tgl_s_q;
   logic       scl_d_q;
   logic       sda_d_q;
   logic       tgl_d_q;

   always_ff @(posedge i_clk) begin
      scl_s_q <= {scl_s_q[0], i_scl};
      sda_s_q <= {sda_s_q[0], i_sda};
      tgl_s_q <= {tgl_s_q[0], lnk.bit_tgl};
      scl_d_q <= scl_s_q[1];
      sda_d_q <= sda_s_q[1];
      tgl_d_q <= tgl_s_q[1];
   end

   logic start_w;
   logic stop_w;
   logic bit_ev_w;
   logic scl_fall_w;
   assign start_w    = scl_s_q[1] & sda_d_q & ~sda_s_q[1];
   assign stop_w     = scl_s_q[1] & ~sda_d_q & sda_s_q[1];
   assign bit_ev_w   = tgl_s_q[1] ^ tgl_d_q;
   assign scl_fall_w = scl_d_q & ~scl_s_q[1];

   ////////////////////////////////////////////////////////////////////////
   osl_pkg::osl_state_t st_q;
   logic [3:0]  cnt_q;
   logic [7:0]  sh_q;
   logic [7:0]  cmd_q;
   logic [7:0]  lo_q;
   logic [7:0]  tx_q;
   logic        ack_q;
   logic        rd_hi_q;
   logic        oe_q;
   logic        store_q;
   logic [15:0] sp_q;
   logic [15:0] up_q;
   logic [10:0] slew_q;
   logic        half_q;
   logic [5:0]  flags_q;
   logic [15:0] ref_q;
   logic [2:0]  slew_sel_q;

   logic [7:0]  byte_w;
   logic        done_w;
   logic [15:0] wd_w;
   logic        ours_w;
   logic        match_w;
   logic        wr_w;
   logic        big_w;
   logic        bad_up_w;
   logic        bad_div_w;
   logic        ls_hit_w;
   logic [15:0] rd_w;
   assign byte_w  = {sh_q[6:0], lnk.bit_val};
   assign done_w  = bit_ev_w && cnt_q == 4'h7;
   assign wd_w    = {byte_w, lo_q};
   assign match_w = byte_w[7:1] == SLAVE_ADDR;
   assign wr_w    = done_w && st_q == osl_pkg::ST_D1;
   assign big_w   = wd_w > osl_pkg::SP_INVALID;
   assign bad_up_w = half_q ? (wd_w < osl_pkg::UP_MIN_HALF || wd_w > osl_pkg::UP_MAX_HALF)
                            : (wd_w < osl_pkg::UP_MIN_FULL || wd_w > osl_pkg::UP_MAX_FULL);
   assign bad_div_w = wd_w[10:0] != osl_pkg::DIV_FULL && wd_w[10:0] != osl_pkg::DIV_HALF;

   always_comb begin
      ours_w = 1'b0;
      unique case (byte_w)
         osl_pkg::CMD_MODE, osl_pkg::CMD_SETPOINT, osl_pkg::CMD_UPPER,
         osl_pkg::CMD_SLEW, osl_pkg::CMD_DIVIDER: ours_w = 1'b1;
         default: ours_w = 1'b0;
      endcase
   end

   // command byte or read address while loop slave
   assign ls_hit_w = done_w && i_loop_slave &&
                     ((st_q == osl_pkg::ST_CMD && ours_w) ||
                      (st_q == osl_pkg::ST_ADDR && match_w && byte_w[0] && cmd_q != osl_pkg::CMD_STORE));

   always_comb begin
      unique case (cmd_q)
         osl_pkg::CMD_MODE:     rd_w = {8'h00, osl_pkg::MODE_BYTE};
         osl_pkg::CMD_SETPOINT: rd_w = sp_q;
         osl_pkg::CMD_UPPER:    rd_w = up_q;
         osl_pkg::CMD_SLEW:     rd_w = {osl_pkg::SLEW_EXP, slew_q};
         osl_pkg::CMD_DIVIDER:  rd_w = {osl_pkg::DIV_EXP, half_q ? osl_pkg::DIV_HALF : osl_pkg::DIV_FULL};
         default:               rd_w = 16'h0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         st_q    <= osl_pkg::ST_IDLE;
         cnt_q   <= 4'h0;
         sh_q    <= 8'h00;
         cmd_q   <= 8'h00;
         lo_q    <= 8'h00;
         tx_q    <= 8'h00;
         ack_q   <= 1'b0;
         rd_hi_q <= 1'b0;
      end else if (start_w) begin
         st_q  <= osl_pkg::ST_ADDR;
         cnt_q <= 4'h0;
      end else if (stop_w) begin
         st_q  <= osl_pkg::ST_IDLE;
         cnt_q <= 4'h0;
      end else if (bit_ev_w) begin
         if (cnt_q == 4'h8) begin
            cnt_q <= 4'h0;
            // ack_q high here means our own address ack, low byte stays loaded
            if (st_q == osl_pkg::ST_RD && !ack_q) begin
               // host nack or second byte sent ends the read
               if (lnk.bit_val || rd_hi_q) begin
                  st_q <= osl_pkg::ST_IDLE;
               end else begin
                  tx_q    <= rd_w[15:8];
                  rd_hi_q <= 1'b1;
               end
            end
         end else begin
            cnt_q <= cnt_q + 4'h1;
            sh_q  <= byte_w;
         end
         if (done_w) begin
            ack_q <= 1'b0;
            unique case (st_q)
               osl_pkg::ST_IDLE: st_q <= osl_pkg::ST_IDLE;
               osl_pkg::ST_ADDR: begin
                  st_q <= osl_pkg::ST_IDLE;
                  if (match_w && !byte_w[0]) begin
                     ack_q <= 1'b1;
                     st_q  <= osl_pkg::ST_CMD;
                  end else if (match_w && !ls_hit_w && cmd_q != osl_pkg::CMD_STORE) begin
                     ack_q   <= 1'b1;
                     st_q    <= osl_pkg::ST_RD;
                     tx_q    <= rd_w[7:0];
                     rd_hi_q <= 1'b0;
                  end
               end
               osl_pkg::ST_CMD: begin
                  cmd_q <= byte_w;
                  st_q  <= osl_pkg::ST_IDLE;
                  if (ours_w && !i_loop_slave) begin
                     ack_q <= 1'b1;
                     st_q  <= osl_pkg::ST_D0;
                  end else if (byte_w == osl_pkg::CMD_STORE) begin
                     ack_q <= 1'b1;
                  end
               end
               osl_pkg::ST_D0: begin
                  lo_q  <= byte_w;
                  ack_q <= 1'b1;
                  st_q  <= osl_pkg::ST_D1;
               end
               osl_pkg::ST_D1: begin
                  ack_q <= !(cmd_q == osl_pkg::CMD_SETPOINT && big_w) && cmd_q != osl_pkg::CMD_MODE;
                  st_q  <= osl_pkg::ST_IDLE;
               end
               osl_pkg::ST_RD: st_q <= osl_pkg::ST_RD;
            endcase
         end
      end
   end

   // data line changes only while the link clock is low
   always_ff @(posedge i_clk) begin
      if (i_srst || start_w || stop_w) begin
         oe_q <= 1'b0;
      end else if (scl_fall_w) begin
         if (cnt_q == 4'h8) begin
            oe_q <= ack_q;
         end else if (st_q == osl_pkg::ST_RD) begin
            oe_q <= ~tx_q[3'(4'h7 - cnt_q)];
         end else begin
            oe_q <= 1'b0;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         store_q <= 1'b0;
      end else begin
         store_q <= done_w && st_q == osl_pkg::ST_CMD && byte_w == osl_pkg::CMD_STORE;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [15:0] sp_new_w;
   always_comb begin
      sp_new_w = wd_w;
      if (half_q) begin
         if (sp_new_w < osl_pkg::SP_MIN_HALF) sp_new_w = osl_pkg::SP_MIN_HALF;
         if (sp_new_w > osl_pkg::SP_MAX_HALF) sp_new_w = osl_pkg::SP_MAX_HALF;
      end else begin
         if (sp_new_w < osl_pkg::SP_MIN_FULL) sp_new_w = osl_pkg::SP_MIN_FULL;
         if (sp_new_w > osl_pkg::SP_MAX_FULL) sp_new_w = osl_pkg::SP_MAX_FULL;
      end
      // upper checked last so it dominates a crossed pair
      if (sp_new_w < i_lower_limit) sp_new_w = i_lower_limit;
      if (sp_new_w > up_q) sp_new_w = up_q;
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         sp_q   <= osl_pkg::SP_RESET;
         up_q   <= osl_pkg::UP_MAX_FULL;
         slew_q <= osl_pkg::SLEW_RESET;
         half_q <= 1'b0;
      end else if (wr_w && !i_loop_slave) begin
         unique case (cmd_q)
            osl_pkg::CMD_SETPOINT: if (!big_w) sp_q <= sp_new_w;
            osl_pkg::CMD_UPPER:    if (!bad_up_w) up_q <= wd_w;
            osl_pkg::CMD_SLEW:     slew_q <= wd_w[10:0];
            osl_pkg::CMD_DIVIDER:  if (!bad_div_w) half_q <= wd_w[10:0] == osl_pkg::DIV_HALF;
            default:               sp_q <= sp_q;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic signed [17:0] sum_w;
   logic [15:0]        eff_w;
   logic               over_w;
   logic               under_w;
   logic [15:0]        ref_sel_w;
   // trim and margin steps arrive pre-summed as one signed offset
   assign sum_w     = signed'({2'b00, sp_q}) + signed'({{2{i_ref_adjust[15]}}, i_ref_adjust});
   assign eff_w     = sum_w[17] ? 16'h0000 : (|sum_w[16] ? 16'hffff : sum_w[15:0]);
   assign over_w    = eff_w > up_q || up_q <= i_lower_limit;
   assign under_w   = eff_w < i_lower_limit;
   assign ref_sel_w = over_w ? up_q : (under_w ? i_lower_limit : eff_w);

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ref_q <= 16'h0000;
      end else begin
         ref_q <= half_q ? {1'b0, ref_sel_w[15:1]} : ref_sel_w;
      end
   end

   logic [5:0] set_w;
   logic       bad_wr_w;
   logic       viol_w;
   assign bad_wr_w = wr_w && ((cmd_q == osl_pkg::CMD_SETPOINT && big_w) ||
                              (cmd_q == osl_pkg::CMD_UPPER && bad_up_w) ||
                              (cmd_q == osl_pkg::CMD_DIVIDER && bad_div_w));
   assign viol_w   = i_output_on && (over_w || under_w);
   always_comb begin
      set_w = 6'h00;
      set_w[osl_pkg::F_COMM_ERR]     = bad_wr_w;
      set_w[osl_pkg::F_INVALID_DATA] = bad_wr_w;
      set_w[osl_pkg::F_INVALID_CMD]  = ls_hit_w;
      set_w[osl_pkg::F_OTHER_COND]   = viol_w;
      set_w[osl_pkg::F_OUTPUT_WARN]  = viol_w;
      set_w[osl_pkg::F_LIMIT_WARN]   = viol_w;
   end

   // a set in the clearing cycle survives
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         flags_q <= 6'h00;
      end else begin
         flags_q <= (flags_q & ~{6{i_flags_clear}}) | set_w;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   logic [6:0] gt_w;
   logic [2:0] sel_w;
   for (genvar g = 0; g < osl_pkg::SLEW_BUCKETS - 1; g++) begin : g_edge
      assign gt_w[g] = slew_q > osl_pkg::SLEW_EDGE[g];
   end

   always_comb begin
      sel_w = 3'h0;
      for (int k = 0; k < osl_pkg::SLEW_BUCKETS - 1; k++) begin
         sel_w = sel_w + {2'b00, gt_w[k]};
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         slew_sel_q <= 3'h6;
      end else begin
         slew_sel_q <= sel_w;
      end
   end

   assign o_sda            = 1'b0;
   assign o_sda_oe         = oe_q;
   assign o_alert_oe       = |flags_q;
   assign o_ref_code       = ref_q;
   assign o_slew_sel       = slew_sel_q;
   assign o_store_req      = store_q;
   assign o_store_setpoint = sp_q;
   assign o_flags          = flags_q;

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   a_big_keep: assert property (wr_w && cmd_q == osl_pkg::CMD_SETPOINT && big_w |=>
      $stable(sp_q) && flags_q[osl_pkg::F_INVALID_DATA] && !ack_q) else $error("big setpoint accepted");
   a_sp_bound: assert property (wr_w && cmd_q == osl_pkg::CMD_SETPOINT && !big_w |=>
      sp_q <= $past(up_q)) else $error("setpoint above upper limit");
   a_ref_upper: assert property (!half_q && over_w ##1 !half_q |->
      ref_q == $past(up_q)) else $error("reference not clamped to upper");
   a_low_warn: assert property (i_output_on && under_w |=>
      flags_q[osl_pkg::F_LIMIT_WARN] && o_alert_oe) else $error("lower violation not flagged");
   a_loop_nack: assert property (ls_hit_w |=> !ack_q && flags_q[osl_pkg::F_INVALID_CMD]
      && st_q == osl_pkg::ST_IDLE) else $error("loop slave access not rejected");
   a_slew_top: assert property (slew_q > 11'h04f |=> o_slew_sel == 3'h7) else $error("slew bucket wrong");
   a_div_keep: assert property (wr_w && cmd_q == osl_pkg::CMD_DIVIDER && bad_div_w |=>
      $stable(half_q) ##1 flags_q[osl_pkg::F_COMM_ERR]) else $error("bad divider stored");
   a_upper_keep: assert property (wr_w && cmd_q == osl_pkg::CMD_UPPER && bad_up_w |=>
      $stable(up_q)) else $error("out of range upper limit stored");
   a_sp_reset: assert property ($fell(i_srst) |-> sp_q == osl_pkg::SP_RESET &&
      up_q == osl_pkg::UP_MAX_FULL) else $error("reset values wrong");
   a_slew_exp: assert property (wr_w && cmd_q == osl_pkg::CMD_SLEW |=>
      slew_q == $past(wd_w[10:0]) && rd_w[15:11] == osl_pkg::SLEW_EXP) else $error("slew exponent writable");
endmodule
`default_nettype wire

/* sim/osl_host.sv */
// management bus host model driving the clock and data pins
`default_nettype none
module osl_host #(
   parameter logic [6:0] ADDR = 7'h24  // arbitrary address
) (
   output logic     o_scl,
   output logic     o_sda_low,
   input  wire logic i_sda
);
   timeunit 1ns;
   timeprecision 100ps;
   // link tick; phases span several ticks so the synced core keeps up
   localparam int TK = 15;
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic tk(input int n);
      #(TK * n + 3);
   endtask
   // also serves as repeated start, entered with the clock low
   task automatic start();
      o_sda_low = 1'b0;
      tk(3);
      o_scl = 1'b1;
      tk(4);
      o_sda_low = 1'b1;
      tk(4);
      o_scl = 1'b0;
   endtask
   task automatic stop();
      tk(3);
      o_sda_low = 1'b1;
      tk(3);
      o_scl = 1'b1;
      tk(4);
      o_sda_low = 1'b0;
      tk(4);
   endtask
   // data changes only while the clock is low
   task automatic bit_io(input logic b, output logic s);
      tk(3);
      o_sda_low = !b;
      tk(3);
      o_scl = 1'b1;
      tk(2);
      s = i_sda;
      tk(2);
      o_scl = 1'b0;
   endtask
   task automatic byte_io(input logic [7:0] w, input logic a_in, output logic [7:0] r, output logic a);
      for (int i = 7; i >= 0; i--) bit_io(w[i], r[i]);
      bit_io(a_in, a);
   endtask
   ////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n, output logic [3:0] nk);
      logic [7:0] r;
      nk = 4'h0;
      start();
      byte_io({ADDR, 1'b0}, 1'b1, r, nk[0]);
      byte_io(cmd, 1'b1, r, nk[1]);
      if (n > 0) byte_io(d[7:0], 1'b1, r, nk[2]);
      if (n > 1) byte_io(d[15:8], 1'b1, r, nk[3]);
      stop();
   endtask
   task automatic rd(input logic [7:0] cmd, output logic [15:0] d, output logic [2:0] nk);
      logic [7:0] r;
      logic       a;
      start();
      byte_io({ADDR, 1'b0}, 1'b1, r, nk[0]);
      byte_io(cmd, 1'b1, r, nk[1]);
      start();
      byte_io({ADDR, 1'b1}, 1'b1, r, nk[2]);
      byte_io(8'hff, 1'b0, d[7:0], a);
      byte_io(8'hff, 1'b1, d[15:8], a);
      stop();
   endtask
endmodule
`default_nettype wire

/* sim/osl_regs_tb.sv */
// self-checking bench for the setpoint and limit register block
`default_nettype none
module osl_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [10:0] EDGE [7] = '{11'h005, 11'h007, 11'h00c, 11'h011, 11'h019, 11'h02f, 11'h04f};
   localparam logic [10:0] SLEW_T [15] = '{11'h005, 11'h006, 11'h007, 11'h008, 11'h00c, 11'h00d, 11'h011,
      11'h012, 11'h019, 11'h01a, 11'h02f, 11'h030, 11'h04f, 11'h050, 11'h7ff};
   localparam logic [15:0] SP_T [5] = '{16'h00b3, 16'h00b2, 16'h034d, 16'h034e, 16'h0b00};
   logic        i_clk, i_srst, i_loop_slave, i_output_on, i_flags_clear;
   logic [15:0] i_lower_limit, i_ref_adjust, d, sp, o_ref_code, o_store_setpoint;
   logic        scl, sda_low, o_sda, o_sda_oe, o_alert_oe, o_store_req;
   logic [2:0]  o_slew_sel, rk;
   logic [5:0]  o_flags;
   logic [3:0]  nk;
   wire logic   sda_w;
   int          err_total, checks, store_cnt, seed_v;
   // pull-up: the wire is high unless someone pulls it low
   assign sda_w = !sda_low && (o_sda_oe ? o_sda : 1'b1);
   osl_host #(.ADDR(7'h24)) host (.o_scl(scl), .o_sda_low(sda_low), .i_sda(sda_w));
   osl_regs #(.SLAVE_ADDR(7'h24)) dut (
      .i_clk(i_clk), .i_srst(i_srst), .i_scl(scl), .i_sda(sda_w), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
      .o_alert_oe(o_alert_oe), .i_loop_slave(i_loop_slave), .i_output_on(i_output_on),
      .i_lower_limit(i_lower_limit), .i_ref_adjust(i_ref_adjust), .i_flags_clear(i_flags_clear),
      .o_ref_code(o_ref_code), .o_slew_sel(o_slew_sel), .o_store_req(o_store_req),
      .o_store_setpoint(o_store_setpoint), .o_flags(o_flags));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   always_ff @(posedge i_clk) begin
      if (i_srst) store_cnt <= 0;
      else if (o_store_req === 1'b1) store_cnt <= store_cnt + 1;
   end
   ////////////////////////////////////////////////////////////
   function automatic logic [15:0] sp_exp(input logic [15:0] v);
      if (v < 16'h00b3) return 16'h00b3;
      if (v > 16'h034d) return 16'h034d;
      return v;
   endfunction
   function automatic logic [2:0] slew_exp(input logic [10:0] m);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < 7; i++) if (m > EDGE[i]) n = n + 3'h1;
      return n;
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic clear();
      step(1);
      i_flags_clear = 1'b1;
      step(1);
      i_flags_clear = 1'b0;
      step(2);
   endtask
   task automatic end_of_test();
      $display("counts: checks=%0d mismatches=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // whole run is about 0.4 ms of bus traffic
   initial begin
      #900_000;
      err_total++;
      end_of_test();
   end
   ////////////////////////////////////////////////////////////
   initial begin
      i_srst = 1'b1;
      i_loop_slave = 1'b0;
      i_output_on = 1'b1;
      i_flags_clear = 1'b0;
      i_lower_limit = 16'h00b3;
      i_ref_adjust = 16'h0000;
      seed_v = $urandom(32'ha621);
      repeat (2) @(posedge i_clk);
      #1;
      i_srst = 1'b0;
      step(4);
      chk(o_store_setpoint, 16'h0100);
      chk(16'(o_slew_sel), 16'h0006);
      chk(o_ref_code, 16'h0100);
      host.rd(8'h20, d, rk);
      chk(d, 16'h0017);
      chk(16'(rk), 16'h0000);
      host.rd(8'h24, d, rk);
      chk(d, 16'h034d);
      $display("test reset done");
      for (int i = 0; i < 10; i++) begin
         d = (i < 5) ? SP_T[i] : 16'($urandom_range(0, 2816));
         host.wr(8'h21, d, 2, nk);
         step(4);
         sp = sp_exp(d);
         chk(16'(nk), 16'h0000);
         chk(o_store_setpoint, sp);
         chk(o_ref_code, sp);
      end
      host.rd(8'h21, d, rk);
      chk(d, sp);
      host.wr(8'h21, 16'h0b01, 2, nk);
      step(4);
      chk(16'(nk), 16'h0008);
      chk(o_store_setpoint, sp);
      chk(16'(o_flags), 16'h0003);
      chk(16'(o_alert_oe), 16'h0001);
      clear();
      $display("test setpoint done");
      host.wr(8'h24, 16'h0119, 2, nk);
      step(4);
      chk(16'(o_flags), 16'h0003);
      host.rd(8'h24, d, rk);
      chk(d, 16'h034d);
      clear();
      host.wr(8'h21, 16'h0300, 2, nk);
      host.wr(8'h24, 16'h011a, 2, nk);
      step(4);
      chk(o_ref_code, 16'h011a);
      chk(16'(o_flags), 16'h0038);
      host.wr(8'h21, 16'h0200, 2, nk);
      step(4);
      chk(o_store_setpoint, 16'h011a);
      clear();
      chk(16'(o_flags), 16'h0000);
      i_output_on = 1'b0;
      i_ref_adjust = 16'h0020;
      clear();
      chk(o_ref_code, 16'h011a);
      chk(16'(o_flags), 16'h0000);
      i_output_on = 1'b1;
      step(3);
      chk(16'(o_flags), 16'h0038);
      i_ref_adjust = 16'h0000;
      host.wr(8'h24, 16'h034d, 2, nk);
      step(1);
      i_lower_limit = 16'h0150;
      clear();
      chk(o_ref_code, 16'h0150);
      chk(16'(o_flags), 16'h0038);
      host.wr(8'h24, 16'h011a, 2, nk);
      step(4);
      chk(o_ref_code, 16'h011a);
      i_lower_limit = 16'h00b3;
      host.wr(8'h24, 16'h034d, 2, nk);
      clear();
      $display("test limits done");
      i_loop_slave = 1'b1;
      host.wr(8'h21, 16'h0123, 2, nk);
      step(4);
      chk(16'(nk[1]), 16'h0001);
      chk(o_store_setpoint, 16'h011a);
      chk(16'(o_flags[2]), 16'h0001);
      i_loop_slave = 1'b0;
      host.wr(8'h11, 16'h0000, 0, nk);
      step(4);
      chk(16'(store_cnt), 16'h0001);
      clear();
      $display("test slave store done");
      for (int i = 0; i < 15; i++) begin
         host.wr(8'h27, {5'h00, SLEW_T[i]}, 2, nk);
         host.rd(8'h27, d, rk);
         chk(d, {5'h1a, SLEW_T[i]});
         chk(16'(o_slew_sel), 16'(slew_exp(SLEW_T[i])));
      end
      host.wr(8'h29, 16'hf003, 2, nk);
      step(4);
      chk(16'(o_flags), 16'h0003);
      chk(o_ref_code, 16'h011a);
      clear();
      host.wr(8'h29, 16'hf002, 2, nk);
      host.wr(8'h24, 16'h069b, 2, nk);
      step(4);
      chk(16'(o_flags), 16'h0003);
      host.wr(8'h24, 16'h069a, 2, nk);
      host.rd(8'h24, d, rk);
      chk(d, 16'h069a);
      step(1);
      i_lower_limit = 16'h0166;
      host.wr(8'h21, 16'h03e8, 2, nk);
      step(4);
      chk(o_ref_code, 16'h01f4);
      // raised lower limit left the old setpoint below it until the write
      chk(16'(o_flags), 16'h003b);
      host.rd(8'h29, d, rk);
      chk(d, 16'hf002);
      $display("test slew divider done");
      end_of_test();
   end
endmodule
`default_nettype wire
